// ---- dv/debug_link_ack_handshake_tb.sv ----
// self-checking bench for the debug acknowledge link, both ends
`timescale 1ns/1ps
module debug_link_ack_handshake_tb;
  logic ref_clk = 1'b0;
  logic reset_n, exec_done, low_power, cmd_start, cmd_read, fixed_wait;
  logic exec_req, ack_busy, cmd_dropped, busy, ack_seen, fetch_data, next_ok;
  logic [31:0] seed = 32'h31C2C527;
  int cnt[8];
  int cyc, t_req, t_ack, t_done, fails, check_count;
  bit ack_on;
  // model queue: 1 expects a fetch pulse, 2 a next-command pulse
  int exp_q[$];
  int lp_tab[8] = '{0, 0, 2, 1, 3, 0, 4, 0};
  logic [7:0] rd_tab = 8'hA9;
  logic [7:0] fw_tab = 8'h6C;
  debug_link_if lnk();
  debug_ack_target debug_ack_target_i (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
    .link(lnk), .i_exec_done(exec_done), .i_low_power(low_power), .o_exec_req(exec_req),
    .o_ack_busy(ack_busy), .o_cmd_dropped(cmd_dropped));
  debug_ack_pod #(.FIXED_WAIT_TICKS(40)) debug_ack_pod_i (.i_ref_clk(ref_clk),
    .i_reset_n(reset_n), .link(lnk), .i_cmd_start(cmd_start), .i_cmd_read(cmd_read),
    .i_fixed_wait(fixed_wait), .o_busy(busy), .o_ack_seen(ack_seen),
    .o_fetch_data(fetch_data), .o_next_ok(next_ok));
  debug_link_chk debug_link_chk_i (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
    .tgt_out(lnk.tgt_out), .tgt_oe(lnk.tgt_oe), .host_out(lnk.host_out),
    .host_oe(lnk.host_oe), .pin_level(lnk.pin_level));
  // clock
  always #10 ref_clk = ~ref_clk;
  // model side: event counts and cycle stamps
  always @(posedge ref_clk) begin
    cyc++;
    if (exec_req === 1'b1) t_req = cyc;
    if (exec_done === 1'b1) t_done = cyc;
    if (lnk.tgt_oe === 1'b1 && !ack_on) t_ack = cyc;
    ack_on = (lnk.tgt_oe === 1'b1);
    cnt[0] += (exec_req === 1'b1);
    cnt[1] += (cmd_dropped === 1'b1);
    cnt[2] += (ack_seen === 1'b1);
    cnt[3] += (fetch_data === 1'b1);
    cnt[4] += (next_ok === 1'b1);
    cnt[5] += (lnk.tgt_oe === 1'b1 && lnk.tgt_out === 1'b0);
    cnt[6] += (lnk.tgt_oe === 1'b1 && lnk.tgt_out === 1'b1);
    cnt[7] += (ack_busy !== lnk.tgt_oe);
    if (fetch_data === 1'b1 || next_ok === 1'b1) begin
      chk_result(int'(fetch_data === 1'b1) + 2 * int'(next_ok === 1'b1));
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input int got, input int lo, input int hi, input string what);
    check_count++;
    if (got < lo || got > hi) begin
      fails++;
      $display("unexpected at %0t: %s got %0d", $time, what, got);
    end
  endtask : chk
  // pod result against the oldest queued expectation
  task automatic chk_result(input int got);
    int want;
    want = (exp_q.size() > 0) ? exp_q.pop_front() : 0;
    chk(got, want, want, "pod result");
  endtask : chk_result
  task automatic stop_test();
    $display("checks %0d, fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // one command; lp: 1 low power in cell, 2 before done, 3 with done, 4 before start
  task automatic run_cmd(input logic rd, input logic fw, input int lp, input int dly);
    int k;
    bit ea;
    ea = (lp == 0 || lp == 3);
    foreach (cnt[i]) cnt[i] = 0;
    low_power = (lp == 4);
    cmd_read = rd;
    fixed_wait = fw;
    exp_q.push_back(rd ? 1 : 2);
    cmd_start = 1'b1;
    @(negedge ref_clk);
    cmd_start = 1'b0;
    if (lp == 1) begin
      repeat (60) @(negedge ref_clk);
      low_power = 1'b1;
    end else if (lp != 4) begin
      for (k = 0; k < 400 && cnt[0] == 0; k++) @(negedge ref_clk);
      repeat (dly) @(negedge ref_clk);
      low_power = (lp == 2);
      @(negedge ref_clk);
      exec_done = 1'b1;
      low_power = (lp >= 2);
      @(negedge ref_clk);
      exec_done = 1'b0;
    end
    k = 0;
    while ((busy !== 1'b0 || lnk.tgt_oe !== 1'b0 || (ea && cnt[6] == 0)) && k < 3000) begin
      @(negedge ref_clk);
      k++;
    end
    repeat (4) @(negedge ref_clk);
    low_power = 1'b0;
    chk(k, 0, 2999, "completion wait");
    chk(exp_q.size(), 0, 0, "result queue left over");
    chk(cnt[0], int'(lp != 1 && lp != 4), int'(lp != 1 && lp != 4), "exec requests");
    chk(cnt[1], int'(lp == 1 || lp == 2), int'(lp == 1 || lp == 2), "drops");
    chk(cnt[6], int'(ea), int'(ea), "speed-up cycles");
    chk(cnt[5], ea ? 121 : 0, ea ? 128 : 0, "ack low cycles");
    chk(cnt[2], int'(ea && !fw), int'(ea && !fw), "ack seen");
    chk(cnt[3], int'(rd), int'(rd), "fetch pulses");
    chk(cnt[4], int'(!rd), int'(!rd), "next pulses");
    chk(cnt[7], 0, 0, "ack busy vs drive");
    if (ea) begin
      chk(t_ack - t_req, 256, (dly == 0) ? 270 : 100000, "ack delay");
      if (t_done - t_req > 260) chk(t_ack - t_done, 1, 16, "ack after done");
    end
  endtask : run_cmd
  // watchdog
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
  // main sequence with a second reset before the last command
  initial begin
    {exec_done, low_power, cmd_start, cmd_read, fixed_wait} = 5'h00;
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    for (int t = 0; t < 8; t++) begin
      if (t == 7) begin
        reset_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(int'(busy === 1'b0 && lnk.tgt_oe === 1'b0), 1, 1, "reset state");
        reset_n = 1'b1;
      end
      seed = lfsr(seed);
      run_cmd(rd_tab[t], fw_tab[t], lp_tab[t], (t == 0) ? 0 : int'(seed[9:0]));
      $display("test %0d done, fails %0d", t, fails);
    end
    stop_test();
  end
endmodule : debug_link_ack_handshake_tb

// ---- dv/debug_link_chk.sv ----
// assertions on the debug link wires between target and pod
`timescale 1ns/1ps
module debug_link_chk (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic tgt_out,
  input wire logic tgt_oe,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic pin_level
);
  localparam int MIN_GAP = 370;
  logic [7:0] low_cnt;
  logic [5:0] drv_cnt;
  logic [9:0] gap_cnt;
  logic pend;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // ack low length, pod drive length, cycles since command start
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt <= 8'h00;
      drv_cnt <= 6'h00;
      gap_cnt <= 10'h000;
      pend <= 1'b0;
    end else begin
      low_cnt <= (tgt_oe && !tgt_out) ? low_cnt + 8'h01 : 8'h00;
      drv_cnt <= host_oe ? drv_cnt + 6'h01 : 6'h00;
      if (host_oe && drv_cnt == 6'h00) begin
        gap_cnt <= 10'h001;
      end else if (gap_cnt != 10'h000 && gap_cnt != 10'h3FF) begin
        gap_cnt <= gap_cnt + 10'h001;
      end
      pend <= host_oe || (pend && !tgt_oe);
    end
  end
  ack_low_len_a: assert property (tgt_oe && tgt_out |->
    low_cnt >= 8'h79 && low_cnt <= 8'h80)
    else $error("ack low length wrong");
  speedup_len_a: assert property (tgt_oe && tgt_out |=> !tgt_oe)
    else $error("speed-up pulse too long");
  ack_order_a: assert property ($rose(tgt_oe) |-> !tgt_out)
    else $error("ack did not start low");
  ack_cause_a: assert property ($rose(tgt_oe) |-> pend)
    else $error("ack without a command");
  ack_delay_a: assert property ($rose(tgt_oe) |-> gap_cnt >= MIN_GAP)
    else $error("ack too early");
  host_drive_a: assert property (!host_oe && drv_cnt != 6'h00 |->
    drv_cnt >= 6'h19 && drv_cnt <= 6'h20)
    else $error("command low length wrong");
  host_level_a: assert property (host_oe |-> !host_out)
    else $error("pod drove high");
  no_fight_a: assert property (!(tgt_oe && host_oe))
    else $error("both ends drive");
  ack_pin_a: assert property (tgt_oe && !tgt_out |-> !pin_level)
    else $error("pin not low in ack");
  ack_cov: cover property ($rose(tgt_oe));
  spd_cov: cover property (tgt_oe && tgt_out);
  cmd_cov: cover property ($fell(host_oe));
endmodule : debug_link_chk

// ---- hdl/debug_ack_pod.sv ----
// pod end of the debug link: issues a command cell and awaits the acknowledge
`timescale 1ns/1ps
`include "debug_link_ack_cfg.svh"
module debug_ack_pod #(
  parameter int SERIAL_DIV = `DLA_SERIAL_DIV,
  parameter int CELL_TICKS = `DLA_CELL_TICKS,
  parameter int CMD_LOW_TICKS = `DLA_CMD_LOW_TICKS,
  parameter int FIXED_WAIT_TICKS = `DLA_FIXED_WAIT_TICKS
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  debug_link_if.host link,
  input wire logic i_cmd_start,
  input wire logic i_cmd_read,
  input wire logic i_fixed_wait,
  output logic o_busy,
  output logic o_ack_seen,
  output logic o_fetch_data,
  output logic o_next_ok
);

  localparam logic [7:0] DIV_LAST = 8'(SERIAL_DIV - 1);
  localparam logic [15:0] CELL_LAST = 16'(CELL_TICKS - 1);
  localparam logic [15:0] LOW_LAST = 16'(CMD_LOW_TICKS - 1);
  localparam logic [15:0] FIXED_LAST = 16'(FIXED_WAIT_TICKS - 1);

  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic tick;
  logic sync1;
  logic sync2;
  logic sync3;
  logic pin_filt;
  logic next_pin_filt;
  debug_link_ack_pkg::pod_state_t state;
  debug_link_ack_pkg::pod_state_t next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic is_read;
  logic next_is_read;
  logic use_fixed;
  logic next_use_fixed;
  logic pin_oe;
  logic next_pin_oe;
  logic ack_seen;
  logic next_ack_seen;
  logic fetch;
  logic next_fetch;
  logic next_ok;
  logic next_next_ok;
  logic busy;
  logic next_busy;

  // own serial tick and pin filter
  assign tick = (div_cnt == DIV_LAST);
  always_comb begin
    next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
    next_pin_filt = pin_filt;
    if (sync2 == sync3) begin
      next_pin_filt = sync3;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt <= 8'h00;
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      pin_filt <= 1'b1;
    end else begin
      div_cnt <= next_div_cnt;
      sync1 <= link.pin_level;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_filt <= next_pin_filt;
    end
  end

  // command cell, then acknowledge wait or fixed wait
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_is_read = is_read;
    next_use_fixed = use_fixed;
    next_ack_seen = 1'b0;
    next_fetch = 1'b0;
    next_next_ok = 1'b0;
    case (state)
      debug_link_ack_pkg::POD_IDLE: begin
        if (i_cmd_start) begin
          next_state = debug_link_ack_pkg::POD_LOW;
          next_cnt = 16'h0000;
          next_is_read = i_cmd_read;
          next_use_fixed = i_fixed_wait;
        end
      end
      debug_link_ack_pkg::POD_LOW: begin
        if (tick) begin
          next_cnt = cnt + 16'h0001;
          if (cnt == LOW_LAST) begin
            next_state = debug_link_ack_pkg::POD_CELL;
          end
        end
      end
      debug_link_ack_pkg::POD_CELL: begin
        if (tick) begin
          next_cnt = cnt + 16'h0001;
          if (cnt == CELL_LAST) begin
            next_state = use_fixed ? debug_link_ack_pkg::POD_FIXED :
                                     debug_link_ack_pkg::POD_WAIT;
            next_cnt = 16'h0000;
          end
        end
      end
      debug_link_ack_pkg::POD_WAIT: begin
        // no time limit on the wait, pin left released
        if (!pin_filt) begin
          next_state = debug_link_ack_pkg::POD_ACK;
        end
      end
      debug_link_ack_pkg::POD_ACK: begin
        if (pin_filt) begin
          next_state = debug_link_ack_pkg::POD_IDLE;
          next_ack_seen = 1'b1;
          next_fetch = is_read;
          next_next_ok = !is_read;
        end
      end
      debug_link_ack_pkg::POD_FIXED: begin
        if (tick) begin
          next_cnt = cnt + 16'h0001;
          if (cnt == FIXED_LAST) begin
            next_state = debug_link_ack_pkg::POD_IDLE;
            next_fetch = is_read;
            next_next_ok = !is_read;
          end
        end
      end
      default: begin
        next_state = debug_link_ack_pkg::POD_IDLE;
      end
    endcase
    next_pin_oe = (next_state == debug_link_ack_pkg::POD_LOW);
    next_busy = (next_state != debug_link_ack_pkg::POD_IDLE);
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= debug_link_ack_pkg::POD_IDLE;
      cnt <= 16'h0000;
      is_read <= 1'b0;
      use_fixed <= 1'b0;
      pin_oe <= 1'b0;
      ack_seen <= 1'b0;
      fetch <= 1'b0;
      next_ok <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      is_read <= next_is_read;
      use_fixed <= next_use_fixed;
      pin_oe <= next_pin_oe;
      ack_seen <= next_ack_seen;
      fetch <= next_fetch;
      next_ok <= next_next_ok;
      busy <= next_busy;
    end
  end

  // pod only ever drives low
  assign link.host_oe = pin_oe;
  assign link.host_out = 1'b0;
  assign o_busy = busy;
  assign o_ack_seen = ack_seen;
  assign o_fetch_data = fetch;
  assign o_next_ok = next_ok;

endmodule : debug_ack_pod

// ---- hdl/debug_ack_target.sv ----
// target end of the debug link: command end detection and acknowledge pulse
`timescale 1ns/1ps
`include "debug_link_ack_cfg.svh"
module debug_ack_target #(
  parameter int SERIAL_DIV = `DLA_SERIAL_DIV,
  parameter int CELL_TICKS = `DLA_CELL_TICKS,
  parameter int MIN_ACK_DELAY = `DLA_MIN_ACK_DELAY,
  parameter int ACK_LOW_TICKS = `DLA_ACK_LOW_TICKS,
  parameter int SPEEDUP_CYCLES = `DLA_SPEEDUP_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  debug_link_if.target link,
  input wire logic i_exec_done,
  input wire logic i_low_power,
  output logic o_exec_req,
  output logic o_ack_busy,
  output logic o_cmd_dropped
);

  localparam logic [7:0] DIV_LAST = 8'(SERIAL_DIV - 1);
  localparam logic [7:0] CELL_LAST = 8'(CELL_TICKS - 1);
  localparam logic [7:0] DELAY_MIN = 8'(MIN_ACK_DELAY);
  localparam logic [7:0] ACK_LAST = 8'(ACK_LOW_TICKS - 1);
  localparam logic [7:0] SPEEDUP_LAST = 8'(SPEEDUP_CYCLES - 1);

  // free-running serial clock divider
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic tick;

  // pin synchroniser and filtered level
  logic sync1;
  logic sync2;
  logic sync3;
  logic pin_filt;
  logic pin_filt_prev;
  logic next_pin_filt;
  logic pin_fall;

  // sequence state
  debug_link_ack_pkg::tgt_state_t state;
  debug_link_ack_pkg::tgt_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic done;
  logic next_done;
  logic exec_req;
  logic next_exec_req;
  logic dropped;
  logic next_dropped;
  logic pin_oe;
  logic next_pin_oe;
  logic pin_out;
  logic next_pin_out;

  // divide the reference clock by eight, independent of other settings
  always_comb begin
    if (div_cnt == DIV_LAST) begin
      next_div_cnt = 8'h00;
    end else begin
      next_div_cnt = div_cnt + 8'h01;
    end
    tick = (div_cnt == DIV_LAST);
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // filtered level follows once stages two and three agree
  always_comb begin
    next_pin_filt = pin_filt;
    if (sync2 == sync3) begin
      next_pin_filt = sync3;
    end
    pin_fall = pin_filt_prev && !pin_filt;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      pin_filt <= 1'b1;
      pin_filt_prev <= 1'b1;
    end else begin
      sync1 <= link.pin_level;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_filt <= next_pin_filt;
      pin_filt_prev <= pin_filt;
    end
  end

  // command cell, execution wait and acknowledge sequence
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_done = done;
    next_exec_req = 1'b0;
    next_dropped = 1'b0;
    case (state)
      debug_link_ack_pkg::TGT_IDLE: begin
        if (pin_fall && !i_low_power) begin
          next_state = debug_link_ack_pkg::TGT_CELL;
          next_cnt = 8'h00;
        end
      end
      debug_link_ack_pkg::TGT_CELL: begin
        if (i_low_power) begin
          next_state = debug_link_ack_pkg::TGT_IDLE;
          next_dropped = 1'b1;
        end else if (tick) begin
          if (cnt == CELL_LAST) begin
            // the 16th tick of the last bit ends the command
            next_state = debug_link_ack_pkg::TGT_EXEC;
            next_cnt = 8'h00;
            next_done = 1'b0;
            next_exec_req = 1'b1;
          end else begin
            next_cnt = cnt + 8'h01;
          end
        end
      end
      debug_link_ack_pkg::TGT_EXEC: begin
        if (i_low_power && !done && !i_exec_done) begin
          // unexecuted command is forgotten, never acknowledged
          next_state = debug_link_ack_pkg::TGT_IDLE;
          next_dropped = 1'b1;
        end else begin
          if (i_exec_done) begin
            next_done = 1'b1;
          end
          if (tick && (cnt < DELAY_MIN)) begin
            next_cnt = cnt + 8'h01;
          end
          if ((done || i_exec_done) && (cnt >= DELAY_MIN)) begin
            next_state = debug_link_ack_pkg::TGT_ACK_LOW;
            next_cnt = 8'h00;
          end
        end
      end
      debug_link_ack_pkg::TGT_ACK_LOW: begin
        if (tick) begin
          if (cnt == ACK_LAST) begin
            next_state = debug_link_ack_pkg::TGT_SPEEDUP;
            next_cnt = 8'h00;
          end else begin
            next_cnt = cnt + 8'h01;
          end
        end
      end
      debug_link_ack_pkg::TGT_SPEEDUP: begin
        if (cnt == SPEEDUP_LAST) begin
          next_state = debug_link_ack_pkg::TGT_IDLE;
          next_cnt = 8'h00;
        end else begin
          next_cnt = cnt + 8'h01;
        end
      end
      default: begin
        next_state = debug_link_ack_pkg::TGT_IDLE;
        next_cnt = 8'h00;
      end
    endcase
    // drive low during the pulse, high during speed-up, else release
    next_pin_oe = (next_state == debug_link_ack_pkg::TGT_ACK_LOW) ||
                  (next_state == debug_link_ack_pkg::TGT_SPEEDUP);
    next_pin_out = (next_state == debug_link_ack_pkg::TGT_SPEEDUP);
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= debug_link_ack_pkg::TGT_IDLE;
      cnt <= 8'h00;
      done <= 1'b0;
      exec_req <= 1'b0;
      dropped <= 1'b0;
      pin_oe <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      done <= next_done;
      exec_req <= next_exec_req;
      dropped <= next_dropped;
      pin_oe <= next_pin_oe;
      pin_out <= next_pin_out;
    end
  end

  // outputs straight from flops
  assign link.tgt_oe = pin_oe;
  assign link.tgt_out = pin_out;
  assign o_exec_req = exec_req;
  assign o_cmd_dropped = dropped;
  assign o_ack_busy = pin_oe;

endmodule : debug_ack_target

// ---- inc/debug_link_ack_cfg.svh ----
// timing counts for the single-wire debug acknowledge link
`ifndef DEBUG_LINK_ACK_CFG_SVH
`define DEBUG_LINK_ACK_CFG_SVH

// reference clock cycles per serial clock tick
`define DLA_SERIAL_DIV 8
// serial ticks in one bit cell; the last one marks command end
`define DLA_CELL_TICKS 16
// least serial ticks from command end to acknowledge start
`define DLA_MIN_ACK_DELAY 32
// serial ticks that the acknowledge holds the pin low
`define DLA_ACK_LOW_TICKS 16
// reference cycles of the driven-high speed-up pulse
`define DLA_SPEEDUP_CYCLES 1
// serial ticks that the pod drives low to issue a command
`define DLA_CMD_LOW_TICKS 4
// serial ticks of the pod's fixed wait in place of the acknowledge
`define DLA_FIXED_WAIT_TICKS 512

`endif

// ---- inc/debug_link_ack_pkg.sv ----
// state types shared by both ends of the debug acknowledge link
package debug_link_ack_pkg;

  // target end sequence
  typedef enum logic [2:0] {
    TGT_IDLE = 3'b000,
    TGT_CELL = 3'b001,
    TGT_EXEC = 3'b010,
    TGT_ACK_LOW = 3'b011,
    TGT_SPEEDUP = 3'b100
  } tgt_state_t;

  // pod end sequence
  typedef enum logic [2:0] {
    POD_IDLE = 3'b000,
    POD_LOW = 3'b001,
    POD_CELL = 3'b010,
    POD_WAIT = 3'b011,
    POD_ACK = 3'b100,
    POD_FIXED = 3'b101
  } pod_state_t;

endpackage : debug_link_ack_pkg

// ---- inc/debug_link_if.sv ----
// single-wire debug link with pull-up, one modport per end
`timescale 1ns/1ps
interface debug_link_if;
  logic tgt_out;
  logic tgt_oe;
  logic host_out;
  logic host_oe;
  logic pin_level;

  // wire level: any end driving low wins, else high (driven or pulled up)
  assign pin_level = !((tgt_oe && !tgt_out) || (host_oe && !host_out));

  modport target (
    input pin_level,
    output tgt_out,
    output tgt_oe
  );

  modport host (
    input pin_level,
    output host_out,
    output host_oe
  );
endinterface : debug_link_if
